// File: design/smd_pkg.sv
/*
  Constants, register map and shared types of the serial master unit.
  Assumes a 100 MHz system clock and a 32-bit classic Wishbone slave port.
*/
// Contract
// - Read-only count of transmit bytes taken in the last transaction.
// - List type 0 plain buffer, 1 stepped buffer mode; resets to 0.
// - Bit order 0 shifts high bit first, 1 low bit first.
// - Phase 0 samples leading, changes trailing; 1 the other way round.
// - Polarity 0 idles clock low, 1 idles high; config resets zero.
// - Fill byte sent after transmit limit when receive limit is larger.
// - Serial transfer begins about one microsecond after the start task.
// - One-hot rate field, 125 kbps up to 8 Mbps, resets to 250 kbps.
// - Transmit limit bounds bytes fetched from the transmit stream.
// - Receive limit bounds bytes delivered to the receive stream.
`default_nettype none

package smd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned START_LAT_NS = 1000;
  localparam int unsigned START_LAT_CYC =
    (START_LAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MIN_SCK_PERIOD_NS = 125;
  localparam int unsigned MIN_HALF_CYC =
    (MIN_SCK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
  // Bit period at the slowest rate; each higher rate bit halves it
  localparam int unsigned RATE_BASE_PERIOD_NS = 8000;
  localparam int unsigned RATE_STEPS = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses)
  localparam logic [11:0] OFF_START = 12'h010;
  localparam logic [11:0] OFF_STATUS = 12'h400;
  localparam logic [11:0] OFF_RATE = 12'h524;
  localparam logic [11:0] OFF_RX_LIMIT = 12'h538;
  localparam logic [11:0] OFF_RX_AMOUNT = 12'h53c;
  localparam logic [11:0] OFF_TX_LIMIT = 12'h548;
  localparam logic [11:0] OFF_TX_AMOUNT = 12'h54c;
  localparam logic [11:0] OFF_LIST = 12'h550;
  localparam logic [11:0] OFF_CONFIG = 12'h554;
  localparam logic [11:0] OFF_FILL = 12'h5c0;

  ////////////////////////////////////////////////////////////////////////////
  // Fields and reset values
  localparam int unsigned CNT_W = 15;
  localparam int unsigned LIST_W = 2;
  localparam int unsigned CFG_W = 3;
  localparam int unsigned CFG_ORDER_BIT = 0;
  localparam int unsigned CFG_CPHA_BIT = 1;
  localparam int unsigned CFG_CPOL_BIT = 2;
  localparam int unsigned RATE_LSB = 25;
  localparam int unsigned START_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam logic [31:0] RATE_RESET = 32'h04000000;
  localparam logic [CFG_W-1:0] CFG_RESET = 3'h0;
  localparam logic [LIST_W-1:0] LIST_RESET = 2'h0;
  localparam logic [7:0] FILL_RESET = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RESET = 15'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    SMD_IDLE,
    SMD_LATENCY,
    SMD_LOAD,
    SMD_SHIFT,
    SMD_DONE
  } smd_state_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } smd_byte_t;

endpackage

`default_nettype wire

// File: design/smd_byte_fifo.sv
/*
  Two-entry byte buffer with valid and ready on both sides.
  Assumes a single clock; read data come straight from storage flops.
*/
`timescale 1ns/1ns
`default_nettype none

module smd_byte_fifo #(
  parameter int unsigned WIDTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic wr;
    logic rd;
    logic [1:0] count;
  } smd_fifo_st_t;

  smd_fifo_st_t fifo_r;
  smd_fifo_st_t fifo_nxt;
  logic push;
  logic pop;

  assign in_ready = (fifo_r.count != 2'h2);
  assign out_valid = (fifo_r.count != 2'h0);
  assign out_data = fifo_r.mem[fifo_r.rd];

  always_comb begin
    fifo_nxt = fifo_r;
    push = in_valid & in_ready;
    pop = out_valid & out_ready;
    if (push) begin
      fifo_nxt.mem[fifo_r.wr] = in_data;
      fifo_nxt.wr = ~fifo_r.wr;
    end
    if (pop) begin
      fifo_nxt.rd = ~fifo_r.rd;
    end
    if (push && !pop) begin
      fifo_nxt.count = fifo_r.count + 2'h1;
    end else if (pop && !push) begin
      fifo_nxt.count = fifo_r.count - 2'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fifo_r <= '0;
    end else begin
      fifo_r <= fifo_nxt;
    end
  end

endmodule

`default_nettype wire

// File: design/smd_core.sv
/*
  Serial master unit: Wishbone register file, transaction sequencer,
  serial clock generator and byte shifter.
  Assumes transmit bytes arrive on a valid/ready stream, received bytes
  leave through a two-entry buffer, and MISO is asynchronous to clk.
*/
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none

module smd_core (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Transmit byte stream
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  // Receive byte stream
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  // Serial pins
  output logic spi_sck,
  output logic spi_mosi,
  output logic spi_cs_n,
  input wire logic spi_miso,
  // Status towards the buffer walker
  output logic stepped_buffer_mode,
  output logic busy
);

  typedef struct packed {
    smd_pkg::smd_state_t st;
    logic [15:0] tmr;
    logic [2:0] bit_idx;
    logic lead_done;
    logic [7:0] tx_sh;
    logic [7:0] rx_sh;
    logic [smd_pkg::CNT_W-1:0] byte_idx;
    logic [smd_pkg::CNT_W-1:0] tx_cnt;
    logic [smd_pkg::CNT_W-1:0] rx_cnt;
    logic sck;
    logic mosi;
    logic cs_n;
    smd_pkg::smd_byte_t push;
    logic [smd_pkg::CNT_W-1:0] tx_limit;
    logic [smd_pkg::CNT_W-1:0] rx_limit;
    logic [smd_pkg::CNT_W-1:0] tx_amount;
    logic [smd_pkg::CNT_W-1:0] rx_amount;
    logic [smd_pkg::LIST_W-1:0] list_type;
    logic [smd_pkg::CFG_W-1:0] cfg;
    logic [31:0] rate;
    logic [7:0] fill;
    logic ack;
    logic [31:0] rdata;
    logic [1:0] miso_sync;
  } smd_core_st_t;

  smd_core_st_t core_r;
  smd_core_st_t core_nxt;
  logic fifo_in_ready;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Half bit period in clk cycles; no rate bit set falls back to slowest, several set bits take the fastest
  function automatic logic [15:0] half_cyc(input logic [31:0] rate);
    int unsigned ns;
    int unsigned cyc;
    ns = smd_pkg::RATE_BASE_PERIOD_NS;
    for (int k = 0; k < int'(smd_pkg::RATE_STEPS); k++) begin
      if (rate[smd_pkg::RATE_LSB + k]) begin
        ns = smd_pkg::RATE_BASE_PERIOD_NS >> k;
      end
    end
    cyc = (ns + 2 * smd_pkg::CLK_PERIOD_NS - 1) /
          (2 * smd_pkg::CLK_PERIOD_NS);
    if (cyc < smd_pkg::MIN_HALF_CYC) begin
      cyc = smd_pkg::MIN_HALF_CYC;
    end
    return cyc[15:0];
  endfunction

  // Position within the byte of bit number idx in shift order
  function automatic logic [2:0] bit_pos(input logic [2:0] idx,
                                         input logic lsb);
    return lsb ? idx : 3'h7 - idx;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        m[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return m;
  endfunction

  function automatic logic [smd_pkg::CNT_W-1:0] cnt_max(
      input logic [smd_pkg::CNT_W-1:0] a,
      input logic [smd_pkg::CNT_W-1:0] b);
    return (a > b) ? a : b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [15:0] half;
    logic cpha;
    logic cpol;
    logic lsb;
    logic miso;
    logic req;
    logic wr;
    logic start;
    logic go;
    logic [7:0] byte_v;
    logic [7:0] rx_new;
    logic [31:0] wv;
    half = half_cyc(core_r.rate);
    cpha = core_r.cfg[smd_pkg::CFG_CPHA_BIT];
    cpol = core_r.cfg[smd_pkg::CFG_CPOL_BIT];
    lsb = core_r.cfg[smd_pkg::CFG_ORDER_BIT];
    miso = core_r.miso_sync[1];
    req = wb_cyc_i & wb_stb_i;
    wr = req & core_r.ack & wb_we_i;
    start = wr && (wb_adr_i[11:2] == smd_pkg::OFF_START[11:2]) &&
            wb_sel_i[0] && wb_dat_i[smd_pkg::START_BIT];
    go = 1'b0;
    byte_v = core_r.fill;
    rx_new = core_r.rx_sh;
    wv = 32'h00000000;
    tx_ready = 1'b0;
    core_nxt = core_r;
    core_nxt.push.valid = 1'b0;
    core_nxt.miso_sync = {core_r.miso_sync[0], spi_miso};

    case (core_r.st)
      smd_pkg::SMD_IDLE: begin
        core_nxt.sck = cpol;
        if (start) begin
          core_nxt.st = smd_pkg::SMD_LATENCY;
          core_nxt.tmr = 16'(smd_pkg::START_LAT_CYC - 1);
          core_nxt.byte_idx = '0;
          core_nxt.tx_cnt = '0;
          core_nxt.rx_cnt = '0;
        end
      end
      smd_pkg::SMD_LATENCY: begin
        if (core_r.tmr != 16'h0000) begin
          core_nxt.tmr = core_r.tmr - 16'h0001;
        end else begin
          core_nxt.cs_n = 1'b0;
          core_nxt.st = smd_pkg::SMD_LOAD;
        end
      end
      smd_pkg::SMD_LOAD: begin
        // Waiting on a free buffer slot keeps a stalled reader lossless
        if (core_r.byte_idx >=
            cnt_max(core_r.tx_limit, core_r.rx_limit)) begin
          core_nxt.st = smd_pkg::SMD_DONE;
        end else if (!core_r.push.valid && fifo_in_ready) begin
          if (core_r.byte_idx < core_r.tx_limit) begin
            if (tx_valid) begin
              tx_ready = 1'b1;
              byte_v = tx_data;
              core_nxt.tx_cnt = core_r.tx_cnt + 1'b1;
              go = 1'b1;
            end
          end else begin
            byte_v = core_r.fill;
            go = 1'b1;
          end
        end
        if (go) begin
          core_nxt.tx_sh = byte_v;
          core_nxt.bit_idx = 3'h0;
          core_nxt.lead_done = 1'b0;
          core_nxt.tmr = half - 16'h0001;
          if (!cpha) begin
            core_nxt.mosi = byte_v[bit_pos(3'h0, lsb)];
          end
          core_nxt.st = smd_pkg::SMD_SHIFT;
        end
      end
      smd_pkg::SMD_SHIFT: begin
        if (core_r.tmr != 16'h0000) begin
          core_nxt.tmr = core_r.tmr - 16'h0001;
        end else begin
          core_nxt.tmr = half - 16'h0001;
          rx_new = core_r.rx_sh;
          rx_new[bit_pos(core_r.bit_idx, lsb)] = miso;
          if (!core_r.lead_done) begin
            core_nxt.sck = ~cpol;
            core_nxt.lead_done = 1'b1;
            if (cpha) begin
              core_nxt.mosi =
                core_r.tx_sh[bit_pos(core_r.bit_idx, lsb)];
            end else begin
              core_nxt.rx_sh = rx_new;
            end
          end else begin
            core_nxt.sck = cpol;
            core_nxt.lead_done = 1'b0;
            if (cpha) begin
              core_nxt.rx_sh = rx_new;
            end else begin
              rx_new = core_r.rx_sh;
            end
            if (core_r.bit_idx == 3'h7) begin
              if (core_r.byte_idx < core_r.rx_limit) begin
                core_nxt.push.valid = 1'b1;
                core_nxt.push.data = rx_new;
                core_nxt.rx_cnt = core_r.rx_cnt + 1'b1;
              end
              core_nxt.byte_idx = core_r.byte_idx + 1'b1;
              core_nxt.st = smd_pkg::SMD_LOAD;
            end else begin
              core_nxt.bit_idx = core_r.bit_idx + 3'h1;
              if (!cpha) begin
                core_nxt.mosi = core_r.tx_sh[
                  bit_pos(core_r.bit_idx + 3'h1, lsb)];
              end
            end
          end
        end
      end
      smd_pkg::SMD_DONE: begin
        core_nxt.cs_n = 1'b1;
        core_nxt.tx_amount = core_r.tx_cnt;
        core_nxt.rx_amount = core_r.rx_cnt;
        core_nxt.st = smd_pkg::SMD_IDLE;
      end
      default: begin
        core_nxt.st = smd_pkg::SMD_IDLE;
      end
    endcase

    //////////////////////////////////////////////////////////////////////////
    // Register port: one wait state, write lands on the acknowledged edge
    core_nxt.ack = req & ~core_r.ack;
    if (req && !core_r.ack) begin
      if (wb_adr_i[11:2] == smd_pkg::OFF_STATUS[11:2]) begin
        core_nxt.rdata = 32'h00000000;
        core_nxt.rdata[smd_pkg::STAT_BUSY_BIT] =
          (core_r.st != smd_pkg::SMD_IDLE);
      end else if (wb_adr_i[11:2] == smd_pkg::OFF_RATE[11:2]) begin
        core_nxt.rdata = core_r.rate;
      end else if (wb_adr_i[11:2] == smd_pkg::OFF_RX_LIMIT[11:2]) begin
        core_nxt.rdata = 32'(core_r.rx_limit);
      end else if (wb_adr_i[11:2] == smd_pkg::OFF_RX_AMOUNT[11:2]) begin
        core_nxt.rdata = 32'(core_r.rx_amount);
      end else if (wb_adr_i[11:2] == smd_pkg::OFF_TX_LIMIT[11:2]) begin
        core_nxt.rdata = 32'(core_r.tx_limit);
      end else if (wb_adr_i[11:2] == smd_pkg::OFF_TX_AMOUNT[11:2]) begin
        core_nxt.rdata = 32'(core_r.tx_amount);
      end else if (wb_adr_i[11:2] == smd_pkg::OFF_LIST[11:2]) begin
        core_nxt.rdata = 32'(core_r.list_type);
      end else if (wb_adr_i[11:2] == smd_pkg::OFF_CONFIG[11:2]) begin
        core_nxt.rdata = 32'(core_r.cfg);
      end else if (wb_adr_i[11:2] == smd_pkg::OFF_FILL[11:2]) begin
        core_nxt.rdata = 32'(core_r.fill);
      end else begin
        core_nxt.rdata = 32'h00000000;
      end
    end
    if (wr) begin
      if (wb_adr_i[11:2] == smd_pkg::OFF_RATE[11:2]) begin
        core_nxt.rate = merge(core_r.rate, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i[11:2] == smd_pkg::OFF_RX_LIMIT[11:2]) begin
        wv = merge(32'(core_r.rx_limit), wb_dat_i, wb_sel_i);
        core_nxt.rx_limit = wv[smd_pkg::CNT_W-1:0];
      end else if (wb_adr_i[11:2] == smd_pkg::OFF_TX_LIMIT[11:2]) begin
        wv = merge(32'(core_r.tx_limit), wb_dat_i, wb_sel_i);
        core_nxt.tx_limit = wv[smd_pkg::CNT_W-1:0];
      end else if (wb_adr_i[11:2] == smd_pkg::OFF_LIST[11:2]) begin
        wv = merge(32'(core_r.list_type), wb_dat_i, wb_sel_i);
        core_nxt.list_type = wv[smd_pkg::LIST_W-1:0];
      end else if (wb_adr_i[11:2] == smd_pkg::OFF_CONFIG[11:2]) begin
        wv = merge(32'(core_r.cfg), wb_dat_i, wb_sel_i);
        core_nxt.cfg = wv[smd_pkg::CFG_W-1:0];
      end else if (wb_adr_i[11:2] == smd_pkg::OFF_FILL[11:2]) begin
        wv = merge(32'(core_r.fill), wb_dat_i, wb_sel_i);
        core_nxt.fill = wv[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_r <= '0;
      core_r.st <= smd_pkg::SMD_IDLE;
      core_r.cs_n <= 1'b1;
      core_r.tx_limit <= smd_pkg::CNT_RESET;
      core_r.rx_limit <= smd_pkg::CNT_RESET;
      core_r.tx_amount <= smd_pkg::CNT_RESET;
      core_r.list_type <= smd_pkg::LIST_RESET;
      core_r.cfg <= smd_pkg::CFG_RESET;
      core_r.rate <= smd_pkg::RATE_RESET;
      core_r.fill <= smd_pkg::FILL_RESET;
    end else begin
      core_r <= core_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer and outputs

  smd_byte_fifo #(
    .WIDTH(8)
  ) u_rx_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(core_r.push.valid),
    .in_data(core_r.push.data),
    .in_ready(fifo_in_ready),
    .out_valid(rx_valid),
    .out_data(rx_data),
    .out_ready(rx_ready)
  );

  assign wb_dat_o = core_r.rdata;
  assign wb_ack_o = core_r.ack;
  assign spi_sck = core_r.sck;
  assign spi_mosi = core_r.mosi;
  assign spi_cs_n = core_r.cs_n;
  assign stepped_buffer_mode = (core_r.list_type == 2'h1);
  assign busy = (core_r.st != smd_pkg::SMD_IDLE);

endmodule

`default_nettype wire

// File: test/smd_core_sva.sv
/*
  Port checker for smd_core: bus handshake, frame timing, streams.
  Assumes one system clock and the active-high asynchronous reset.
*/
`timescale 1ns/1ns
`default_nettype none

module smd_core_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // Streams
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic [7:0] rx_data,
  // Serial side and status
  input wire logic spi_sck,
  input wire logic spi_mosi,
  input wire logic spi_cs_n,
  input wire logic stepped_buffer_mode,
  input wire logic busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////
  // Shadow of the frame settings, so edge roles are known
  logic [2:0] cfg_r;
  logic wr_ack;
  logic list_one;
  logic samp;
  assign wr_ack = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i;
  assign list_one = wb_dat_i[1:0] == 2'h1;
  assign samp = (spi_sck != cfg_r[2]) ^ cfg_r[1];
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      cfg_r <= 3'h0;
    else if (wr_ack && wb_sel_i[0]
             && wb_adr_i[11:2] == smd_pkg::OFF_CONFIG[11:2])
      cfg_r <= wb_dat_i[2:0];
  end

  sequence s_start;
    wr_ack && wb_dat_i[0] && !busy
      && wb_adr_i[11:2] == smd_pkg::OFF_START[11:2];
  endsequence
  sequence s_list_wr;
    wr_ack && wb_sel_i[0] && wb_adr_i[11:2] == smd_pkg::OFF_LIST[11:2];
  endsequence

  ////////////////////////////////////////////////////////////
  AST_ACK_NEXT: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered in the next cycle");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held longer than one cycle");
  AST_BUSY_RISE: assert property (s_start |=> busy)
    else $error("busy did not follow the start write");
  AST_START_LAT: assert property (s_start |-> ##[95:105] !spi_cs_n)
    else $error("select did not fall about 1 us after start");
  AST_IDLE_CLK: assert property (
    spi_cs_n && $past(spi_cs_n) && $stable(cfg_r) |-> spi_sck == cfg_r[2])
    else $error("serial clock not at its idle level");
  AST_SCK_HALF: assert property (
    !spi_cs_n && $changed(spi_sck) |=> $stable(spi_sck) [*6])
    else $error("serial clock half period below 7 cycles");
  AST_MOSI_SETUP: assert property (
    !spi_cs_n && $past(spi_cs_n) == 1'b0 && $changed(spi_sck) && samp
      |-> $stable(spi_mosi))
    else $error("data changed on the sampling edge");
  AST_CS_BUSY: assert property (!spi_cs_n |-> busy)
    else $error("select low outside a transaction");
  AST_TX_TAKE: assert property (tx_ready |-> tx_valid && busy)
    else $error("transmit byte taken outside a transaction");
  AST_LIST: assert property (
    s_list_wr |=> stepped_buffer_mode == $past(list_one))
    else $error("list mode output does not follow its field");
  AST_RX_HOLD: assert property (
    rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("received byte lost while stalled");
endmodule

bind smd_core smd_core_sva u_smd_core_sva (.clk, .rst, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .tx_valid, .tx_ready,
  .rx_valid, .rx_ready, .rx_data, .spi_sck, .spi_mosi, .spi_cs_n,
  .stepped_buffer_mode, .busy);

`default_nettype wire

// File: test/smd_slave_model.sv
/*
  Behavioural serial slave: sends a counting byte pattern, records bytes.
  Assumes the bench hands it the frame settings written to the master.
*/
`timescale 1ns/1ns
`default_nettype none

module smd_slave_model (
  // Serial pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  // Frame settings and data
  input wire logic cpol,
  input wire logic cpha,
  input wire logic lsb,
  input wire logic [7:0] base,
  output logic [7:0] got [8],
  output int n_got
);
  logic [7:0] cur;
  logic [7:0] sh;
  int k;

  function automatic logic pick(input logic [7:0] b, input int i);
    return lsb ? b[i] : b[7 - i];
  endfunction

  initial begin
    miso = 1'b0;
    n_got = 0;
  end

  // Leading-edge sampling needs the first bit before the first edge
  always @(negedge cs_n) begin
    n_got = 0;
    k = 0;
    cur = base;
    if (!cpha)
      miso = pick(cur, 0);
  end

  // A released line must not look like a held bit
  always @(posedge cs_n)
    miso = ~miso;

  always @(sck) begin
    if (cs_n === 1'b0) begin
      if ((sck != cpol) ^ cpha) begin
        sh = lsb ? {mosi, sh[7:1]} : {sh[6:0], mosi};
        k = k + 1;
        if (k == 8) begin
          got[n_got & 7] = sh;
          n_got = n_got + 1;
          cur = cur + 8'h01;
          k = 0;
        end
      end else begin
        miso = pick(cur, k);
      end
    end
  end
endmodule

`default_nettype wire

// File: test/smd_core_tb.sv
/*
  Self-checking bench for smd_core with a behavioural serial slave.
  Assumes the package, checker and slave model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module smd_core_tb;
  logic clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [11:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic tx_valid, tx_ready, rx_valid, rx_ready, sck_q;
  logic [7:0] tx_data, rx_data, fill, base;
  logic spi_sck, spi_mosi, spi_cs_n, spi_miso, stepped_buffer_mode, busy;
  logic [2:0] cfg;
  logic [7:0] txb [4];
  logic [7:0] got [8];
  logic [11:0] rst_adr [5] = '{smd_pkg::OFF_TX_AMOUNT, smd_pkg::OFF_LIST,
    smd_pkg::OFF_CONFIG, smd_pkg::OFF_RATE, 12'h7f0};
  logic [31:0] rst_val [5] = '{32'h0, 32'h0, 32'h0, smd_pkg::RATE_RESET,
    32'h0};
  // Byte lanes of the next access; a partial mask checks lane gating
  logic [3:0] sel_v = 4'hf;
  int n_got, tx_n, tx_i, rx_i, hp_cnt, hp_min, cyc_n, tl, rl, r, mx;
  int mismatches, n_compared;

  smd_core u_smd_core (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .tx_valid, .tx_data,
    .tx_ready, .rx_valid, .rx_data, .rx_ready, .spi_sck, .spi_mosi,
    .spi_cs_n, .spi_miso, .stepped_buffer_mode, .busy);
  smd_slave_model u_smd_slave_model (.sck(spi_sck), .cs_n(spi_cs_n),
    .mosi(spi_mosi), .miso(spi_miso), .cpol(cfg[2]), .cpha(cfg[1]),
    .lsb(cfg[0]), .base, .got, .n_got);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic give_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic wb(input logic we, input logic [11:0] a,
                    input logic [31:0] d, output logic [31:0] rd);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= sel_v;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask

  function automatic int half(input int rate);
    return ((smd_pkg::RATE_BASE_PERIOD_NS >> rate) + 19) / 20;
  endfunction

  ////////////////////////////////////////////////////////////
  // Source stalls at random but never withdraws an offered byte
  always @(posedge clk) begin
    if (tx_valid !== 1'b1 || tx_ready === 1'b1) begin
      if (tx_valid === 1'b1)
        tx_i = tx_i + 1;
      tx_valid <= tx_i < tx_n && $urandom_range(2) != 0;
      tx_data <= txb[tx_i & 3];
    end
  end

  always @(posedge clk) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      cmp(rx_data, 8'(base + rx_i));
      rx_i = rx_i + 1;
    end
    rx_ready <= 1'($urandom_range(1));
  end

  // Shortest serial clock interval, and the run's time limit
  always @(posedge clk) begin
    cyc_n++;
    hp_cnt++;
    if (spi_sck !== sck_q) begin
      if (spi_cs_n === 1'b0 && hp_cnt < hp_min)
        hp_min = hp_cnt;
      hp_cnt = 0;
    end
    sck_q = spi_sck;
    if (cyc_n == 40000) begin
      mismatches++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, tx_valid, rx_ready, sck_q} = '0;
    {wb_adr_i, wb_dat_i, tx_data, cfg, base} = '0;
    wb_sel_i = 4'hf;
    {tx_n, tx_i, rx_i, hp_cnt, hp_min, cyc_n, mismatches, n_compared} = '0;
    rst = 1'b1;
    q = $urandom(66);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      wb(1'b0, rst_adr[i], 32'h0, q);
      cmp(q, rst_val[i]);
    end
    wb(1'b1, smd_pkg::OFF_TX_AMOUNT, 32'h5, q);
    wb(1'b0, smd_pkg::OFF_TX_AMOUNT, 32'h0, q);
    cmp(q, 32'h0);
    wb(1'b1, smd_pkg::OFF_LIST, 32'h1, q);
    cmp({31'h0, stepped_buffer_mode}, 32'h1);
    wb(1'b1, smd_pkg::OFF_LIST, 32'h0, q);
    cmp({31'h0, stepped_buffer_mode}, 32'h0);
    wb(1'b1, smd_pkg::OFF_FILL, 32'h000000a5, q);
    sel_v = 4'he;
    wb(1'b1, smd_pkg::OFF_FILL, 32'h0000005a, q);
    sel_v = 4'hf;
    wb(1'b0, smd_pkg::OFF_FILL, 32'h0, q);
    cmp(q, 32'h000000a5);
    // Every order, phase and polarity; all-fill and transmit-only corners
    for (int m = 0; m < 8; m++) begin
      tl = (m == 1) ? 0 : 1 + $urandom_range(2);
      rl = (m == 1) ? 3 : (m == 2) ? 0 : $urandom_range(3);
      mx = tl > rl ? tl : rl;
      r = 4 + m % 3;
      cfg = m[2:0];
      fill = 8'($urandom);
      base = 8'($urandom);
      foreach (txb[i])
        txb[i] = 8'($urandom);
      wb(1'b1, smd_pkg::OFF_RATE, 32'h02000000 << r, q);
      wb(1'b1, smd_pkg::OFF_TX_LIMIT, 32'(tl), q);
      wb(1'b1, smd_pkg::OFF_RX_LIMIT, 32'(rl), q);
      wb(1'b1, smd_pkg::OFF_CONFIG, {29'h0, cfg}, q);
      wb(1'b1, smd_pkg::OFF_FILL, {24'h0, fill}, q);
      tx_i = 0;
      rx_i = 0;
      tx_n = tl;
      hp_min = 1000;
      wb(1'b1, smd_pkg::OFF_START, 32'h1, q);
      while (spi_cs_n !== 1'b0)
        @(posedge clk);
      wb(1'b0, smd_pkg::OFF_STATUS, 32'h0, q);
      cmp(q, 32'h1);
      while (busy !== 1'b0)
        @(posedge clk);
      repeat (20) @(posedge clk);
      wb(1'b0, smd_pkg::OFF_TX_AMOUNT, 32'h0, q);
      cmp(q, 32'(tl));
      wb(1'b0, smd_pkg::OFF_RX_AMOUNT, 32'h0, q);
      cmp(q, 32'(rl));
      cmp(tx_i, tl);
      cmp(rx_i, rl);
      cmp(n_got, mx);
      cmp(hp_min, half(r));
      for (int i = 0; i < mx; i++)
        cmp(got[i], i < tl ? txb[i] : fill);
    end
    give_verdict();
  end
endmodule

`default_nettype wire
